// File: qflash_pkg.sv
package qflash_pkg;

  // Opcodes understood by the decoder in four-line mode.
  localparam logic [7:0] op_wr_enable   = 8'h06;
  localparam logic [7:0] op_vol_enable  = 8'h50;
  localparam logic [7:0] op_wr_disable  = 8'h04;
  localparam logic [7:0] op_rd_stat1    = 8'h05;
  localparam logic [7:0] op_wr_stat     = 8'h01;
  localparam logic [7:0] op_rd_stat2    = 8'h35;
  localparam logic [7:0] op_wr_stat2    = 8'h31;
  localparam logic [7:0] op_rd_stat3    = 8'h15;
  localparam logic [7:0] op_wr_stat3    = 8'h11;
  localparam logic [7:0] op_chip_era_a  = 8'hC7;
  localparam logic [7:0] op_chip_era_b  = 8'h60;
  localparam logic [7:0] op_suspend     = 8'h75;
  localparam logic [7:0] op_resume      = 8'h7A;
  localparam logic [7:0] op_power_down  = 8'hB9;
  localparam logic [7:0] op_set_param   = 8'hC0;
  localparam logic [7:0] op_release_id  = 8'hAB;
  localparam logic [7:0] op_qio_read4   = 8'hEC;
  localparam logic [7:0] op_param_table = 8'h5A;
  localparam logic [7:0] op_prog4       = 8'h12;
  localparam logic [7:0] op_era4k_4     = 8'h21;
  localparam logic [7:0] op_era32k_4    = 8'h5C;
  localparam logic [7:0] op_era64k_4    = 8'hDC;
  localparam logic [7:0] op_prog        = 8'h02;
  localparam logic [7:0] op_era4k       = 8'h20;
  localparam logic [7:0] op_era32k      = 8'h52;
  localparam logic [7:0] op_era64k      = 8'hD8;
  localparam logic [7:0] op_fast_read   = 8'h0B;
  localparam logic [7:0] op_wrap_read   = 8'h0C;
  localparam logic [7:0] op_qio_read    = 8'hEB;
  localparam logic [7:0] op_unique_id   = 8'h4B;
  localparam logic [7:0] op_sec_read    = 8'h48;
  localparam logic [7:0] op_sec_erase   = 8'h44;
  localparam logic [7:0] op_sec_prog    = 8'h42;
  localparam logic [7:0] op_lock_read   = 8'h3D;
  localparam logic [7:0] op_lock        = 8'h36;
  localparam logic [7:0] op_unlock      = 8'h39;
  localparam logic [7:0] op_enter_4b    = 8'hB7;
  localparam logic [7:0] op_exit_4b     = 8'hE9;
  localparam logic [7:0] op_rd_upper    = 8'hC8;
  localparam logic [7:0] op_wr_upper    = 8'hC5;
  localparam logic [7:0] op_rst_enable  = 8'h66;
  localparam logic [7:0] op_rst_device  = 8'h99;

  // Values after reset.
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] upper_reset  = 8'h00;
  localparam logic [7:0] param_reset  = 8'h00;

  typedef logic [1:0] wrap_sel_type;
  typedef enum logic [2:0] {kind_none, kind_write, kind_repeat, kind_stream, kind_uid} kind_type;
  typedef struct packed {
    logic [2:0] addr_bytes;
    logic [2:0] dummy_bytes;
    kind_type   kind;
    logic       needs_wel;
  } cmd_info_type;

  // Frame layout of one opcode; the address width follows the current mode unless the opcode fixes three or four bytes.
  function automatic cmd_info_type cmd_info(input logic [7:0] op, input logic four_byte);
    logic [2:0]   na;
    cmd_info_type ci;
    na = four_byte ? 3'h4 : 3'h3;
    ci = '{3'h0, 3'h0, kind_none, 1'b0};
    case (op)
      op_rd_stat1, op_rd_stat2, op_rd_stat3, op_rd_upper: ci.kind = kind_repeat;
      op_wr_stat, op_wr_stat2, op_wr_stat3, op_wr_upper, op_set_param: ci.kind = kind_write;
      op_release_id: ci = '{3'h0, 3'h3, kind_repeat, 1'b0};
      op_qio_read4: ci = '{3'h4, 3'h2, kind_stream, 1'b0};
      op_param_table: ci = '{3'h3, 3'h1, kind_stream, 1'b0};
      op_prog4: ci = '{3'h4, 3'h0, kind_write, 1'b1};
      op_era4k_4, op_era32k_4, op_era64k_4: ci = '{3'h4, 3'h0, kind_none, 1'b1};
      op_prog, op_sec_prog: ci = '{na, 3'h0, kind_write, 1'b1};
      op_era4k, op_era32k, op_era64k, op_sec_erase, op_lock, op_unlock:
        ci = '{na, 3'h0, kind_none, 1'b1};
      op_fast_read, op_wrap_read, op_sec_read: ci = '{na, 3'h1, kind_stream, 1'b0};
      op_qio_read: ci = '{na, 3'h2, kind_stream, 1'b0};
      op_unique_id: ci = '{3'h0, 3'h4, kind_uid, 1'b0};
      op_lock_read: ci = '{na, 3'h0, kind_repeat, 1'b0};
      op_chip_era_a, op_chip_era_b: ci.needs_wel = 1'b1;
      default: ci.kind = kind_none;
    endcase
    return ci;
  endfunction

endpackage

// File: link_if.sv
`timescale 1ns/100ps
// Sampled view of the serial link, all on clk.
interface link_if;
  logic       rise;
  logic       fall;
  logic [3:0] nib;
  logic       cs_active;
  logic       frame_end;
  modport sampler (output rise, fall, nib, cs_active, frame_end);
  modport decoder (input rise, fall, nib, cs_active, frame_end);
endinterface

// File: link_sampler.sv
`timescale 1ns/100ps
module link_sampler (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] io_in,
  link_if.sampler        lk
);

  logic [2:0] sclk_q;
  logic [2:0] csn_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;

  // Two stages before use; the third stage only serves edge detection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q  <= 3'h0;
      csn_q   <= 3'h7;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      sclk_q  <= {sclk_q[1:0], sclk};
      csn_q   <= {csn_q[1:0], cs_n};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  // Data lines pass the same two stages as the clock, so they stay aligned with its edge.
  assign lk.cs_active = !csn_q[1];
  assign lk.rise      = sclk_q[1] && !sclk_q[2] && !csn_q[1];
  assign lk.fall      = !sclk_q[1] && sclk_q[2] && !csn_q[1];
  assign lk.nib       = io_s2_q;
  assign lk.frame_end = csn_q[1] && !csn_q[2];

endmodule

// File: quad_serial_flash_cmd_decoder.sv
`timescale 1ns/100ps
module quad_serial_flash_cmd_decoder #(
  parameter logic [7:0] device_ident = 8'h5A,  // Arbitrary value.
  parameter int         page_bytes   = 256
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic [3:0]              io_in,
  output logic [3:0]                   io_out,
  output logic [3:0]                   io_oe,
  input  wire qflash_pkg::wrap_sel_type wrap_sel,
  input  wire logic [7:0]              read_data,
  input  wire logic [7:0]              lock_data,
  input  wire logic [127:0]            unique_identifier,
  output logic [31:0]                  read_addr,
  output logic [31:0]                  cmd_addr,
  output logic                         exec_req,
  output logic [7:0]                   exec_op,
  output logic                         prog_valid,
  output logic [31:0]                  prog_addr,
  output logic [7:0]                   prog_data,
  output logic [7:0]                   status_byte_one,
  output logic [7:0]                   status_byte_two,
  output logic [7:0]                   status_byte_three,
  output logic [7:0]                   read_parameter_byte,
  output logic [7:0]                   upper_address_byte,
  output logic                         write_enable_latch,
  output logic                         four_byte_mode,
  output logic                         power_down,
  output logic                         suspend_req,
  output logic                         resume_req,
  output logic                         soft_reset
);
  import qflash_pkg::*;

  if (page_bytes > 256 || page_bytes < 1 || (page_bytes & (page_bytes - 1)) != 0) begin : g_chk
    $error("page_bytes must be a power of two up to 256");
  end

  link_if lk ();
  link_sampler u_sampler (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
                          .lk(lk.sampler));

  logic         half_q, tx_on_q, wel_q, vol_q, four_q, pd_q, armed_q, oe_q;
  logic [3:0]   hold_q, idx_q, io_q;
  logic [7:0]   op_q, tx_q, cnt_q, sr1_q, sr2_q, sr3_q, upper_q, param_q, pend1_q, pend2_q;
  logic [1:0]   wr_cnt_q;
  logic [31:0]  addr_q, rd_q;
  logic         susp_q, res_q, srst_q, exec_q, pv_q;
  logic [7:0]   exec_op_q, pdata_q;
  logic [31:0]  paddr_q;

  // Byte assembly: high nibble first, a byte closes on every second rising edge.
  logic         byte_done;
  logic [7:0]   rx_byte, op_now, src_byte;
  cmd_info_type info;
  logic [3:0]   hdr, nidx;
  logic         in_addr, in_data, load_tx, wr_ok;
  logic [31:0]  addr_next, rd_inc;
  logic [6:0]   wmask;
  assign byte_done = lk.rise && half_q;
  assign rx_byte   = {hold_q, lk.nib};
  assign op_now    = (idx_q == 4'h0) ? rx_byte : op_q;
  assign info      = cmd_info(op_now, four_q);
  assign hdr       = 4'h1 + {1'b0, info.addr_bytes} + {1'b0, info.dummy_bytes};
  assign nidx      = (idx_q == 4'hF) ? idx_q : idx_q + 4'h1;
  assign in_addr   = idx_q != 4'h0 && idx_q <= {1'b0, info.addr_bytes};
  assign in_data   = idx_q >= hdr;
  assign load_tx   = byte_done && nidx >= hdr && (!pd_q || op_now == op_release_id)
                     && (info.kind == kind_repeat || info.kind == kind_stream
                     || info.kind == kind_uid);
  assign wr_ok     = wel_q && !pd_q;
  assign addr_next = (info.addr_bytes == 3'h4) ? {addr_q[23:0], rx_byte}
                     : {upper_q, addr_q[15:0], rx_byte};
  // Wrapped reads stay inside an aligned 8 to 64 byte window.
  assign wmask     = 7'(({1'b0, 6'h08} << wrap_sel) - 7'h01);
  assign rd_inc    = (op_q == op_wrap_read)
                     ? {rd_q[31:7], (rd_q[6:0] & ~wmask) | ((rd_q[6:0] + 7'h01) & wmask)}
                     : rd_q + 32'h0000_0001;

  // Byte presented in the next slot; status and ident sources repeat.
  always_comb begin
    src_byte = read_data;
    case (op_now)
      op_rd_stat1:   src_byte = sr1_q;
      op_rd_stat2:   src_byte = sr2_q;
      op_rd_stat3:   src_byte = sr3_q;
      op_rd_upper:   src_byte = upper_q;
      op_release_id: src_byte = device_ident;
      op_lock_read:  src_byte = lock_data;
      op_unique_id:  src_byte = unique_identifier[8'(8'd127 - {cnt_q[3:0], 3'h0}) -: 8];
      default:       src_byte = read_data;
    endcase
  end

  // Frame sequencing and the transmit byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0; hold_q <= 4'h0; idx_q <= 4'h0; op_q <= 8'h00; tx_q <= 8'h00;
      tx_on_q <= 1'b0; cnt_q <= 8'h00; addr_q <= 32'h0000_0000; rd_q <= 32'h0000_0000;
    end else if (!lk.cs_active) begin
      half_q <= 1'b0; idx_q <= 4'h0; tx_on_q <= 1'b0; cnt_q <= 8'h00;
    end else if (lk.rise) begin
      half_q <= !half_q;
      if (!half_q) hold_q <= lk.nib;
      if (byte_done) begin
        idx_q <= nidx;
        if (idx_q == 4'h0) op_q <= rx_byte;
        if (in_addr) begin
          addr_q <= addr_next;
          rd_q   <= addr_next;
        end
        // Loaded bytes count as well, so the identifier moves on after its first byte.
        if (in_data || load_tx) cnt_q <= cnt_q + 8'h01;
        if (load_tx) begin
          tx_q    <= src_byte;
          tx_on_q <= 1'b1;
          // Every loaded stream byte advances the address, so no byte is sent twice.
          if (info.kind == kind_stream) rd_q <= rd_inc;
        end
      end
    end
  end

  // Outgoing nibbles change on the falling edge, high half first.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_q <= 4'h0; oe_q <= 1'b0;
    end else if (!lk.cs_active) begin
      oe_q <= 1'b0;
    end else if (lk.fall) begin
      io_q <= half_q ? tx_q[3:0] : tx_q[7:4];
      oe_q <= tx_on_q;
    end
  end

  // Incoming write data: status bytes are held until the frame closes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend1_q <= 8'h00; pend2_q <= 8'h00; wr_cnt_q <= 2'h0;
      pv_q <= 1'b0; paddr_q <= 32'h0000_0000; pdata_q <= 8'h00;
    end else begin
      pv_q <= 1'b0;
      if (!lk.cs_active) wr_cnt_q <= 2'h0;
      else if (byte_done && in_data && info.kind == kind_write) begin
        if (wr_cnt_q == 2'h0) pend1_q <= rx_byte;
        if (wr_cnt_q == 2'h1) pend2_q <= rx_byte;
        if (wr_cnt_q != 2'h3) wr_cnt_q <= wr_cnt_q + 2'h1;
        if (info.needs_wel && wr_ok) begin
          pv_q    <= 1'b1;
          pdata_q <= rx_byte;
          paddr_q <= (addr_q & ~32'(page_bytes - 1)) |
                     ((addr_q + 32'(cnt_q)) & 32'(page_bytes - 1));
        end
      end
    end
  end

  // Commands take effect when chip select rises on a byte boundary.
  logic done, one_byte, sr_ok;
  assign done     = lk.frame_end && !half_q;
  assign one_byte = done && idx_q == 4'h1;
  assign sr_ok    = (wel_q || vol_q) && !pd_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr1_q <= status_reset; sr2_q <= status_reset; sr3_q <= status_reset;
      upper_q <= upper_reset; param_q <= param_reset; wel_q <= 1'b0; vol_q <= 1'b0;
      four_q <= 1'b0; pd_q <= 1'b0; armed_q <= 1'b0; susp_q <= 1'b0; res_q <= 1'b0;
      srst_q <= 1'b0; exec_q <= 1'b0; exec_op_q <= 8'h00;
    end else begin
      susp_q <= 1'b0; res_q <= 1'b0; srst_q <= 1'b0; exec_q <= 1'b0;
      if (lk.frame_end) begin
        armed_q <= one_byte && op_q == op_rst_enable;
        if (one_byte && op_q == op_rst_device && armed_q) begin
          srst_q <= 1'b1; wel_q <= 1'b0; vol_q <= 1'b0; four_q <= 1'b0;
          upper_q <= upper_reset; pd_q <= 1'b0;
        end else if (pd_q) begin
          if (done && op_q == op_release_id) pd_q <= 1'b0;
        end else if (done) begin
          case (op_q)
            op_wr_enable:  wel_q <= one_byte;
            op_wr_disable: if (one_byte) wel_q <= 1'b0;
            op_vol_enable: vol_q <= one_byte;
            op_suspend:    susp_q <= one_byte;
            op_resume:     res_q <= one_byte;
            op_power_down: pd_q <= one_byte;
            op_enter_4b:   if (one_byte) four_q <= 1'b1;
            op_exit_4b:    if (one_byte) four_q <= 1'b0;
            op_wr_upper:   if (wr_cnt_q != 2'h0) upper_q <= pend1_q;
            op_set_param:  if (wr_cnt_q != 2'h0) param_q <= pend1_q;
            op_wr_stat, op_wr_stat2, op_wr_stat3: if (sr_ok && wr_cnt_q != 2'h0) begin
              if (op_q == op_wr_stat) sr1_q <= pend1_q;
              if (op_q == op_wr_stat && wr_cnt_q != 2'h1) sr2_q <= pend2_q;
              if (op_q == op_wr_stat2) sr2_q <= pend1_q;
              if (op_q == op_wr_stat3) sr3_q <= pend1_q;
              wel_q <= 1'b0; vol_q <= 1'b0;
            end
            default: if (info.needs_wel && wr_ok && idx_q >= hdr) begin
              exec_q    <= info.kind != kind_write;
              exec_op_q <= op_q;
              wel_q     <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  assign io_out              = io_q;
  assign io_oe               = {4{oe_q}};
  assign read_addr           = rd_q;
  assign cmd_addr            = addr_q;
  assign exec_req            = exec_q;
  assign exec_op             = exec_op_q;
  assign prog_valid          = pv_q;
  assign prog_addr           = paddr_q;
  assign prog_data           = pdata_q;
  assign status_byte_one     = sr1_q;
  assign status_byte_two     = sr2_q;
  assign status_byte_three   = sr3_q;
  assign read_parameter_byte = param_q;
  assign upper_address_byte  = upper_q;
  assign write_enable_latch  = wel_q;
  assign four_byte_mode      = four_q;
  assign power_down          = pd_q;
  assign suspend_req         = susp_q;
  assign resume_req          = res_q;
  assign soft_reset          = srst_q;

  // Checks that tie outputs to their causes.
  chk_byte_pairs: assert property (@(posedge clk) disable iff (rst)
    lk.rise && lk.cs_active |=> half_q != $past(half_q)) else $error("nibble phase stuck");
  chk_msb_first: assert property (@(posedge clk) disable iff (rst)
    lk.rise && !half_q |=> hold_q == $past(lk.nib)) else $error("high nibble not held");
  chk_stat_read: assert property (@(posedge clk) disable iff (rst)
    byte_done && idx_q == 4'h0 && rx_byte == op_rd_stat1 && !pd_q |=> tx_q == $past(sr1_q))
    else $error("status byte one not loaded");
  chk_prog_gate: assert property (@(posedge clk) disable iff (rst)
    prog_valid |-> $past(wel_q)) else $error("program without write enable");
  chk_page_wrap: assert property (@(posedge clk) disable iff (rst)
    prog_valid |-> (prog_addr & ~32'(page_bytes - 1)) == (cmd_addr & ~32'(page_bytes - 1)))
    else $error("program left its page");
  chk_reset_pair: assert property (@(posedge clk) disable iff (rst)
    soft_reset |-> $past(armed_q, 1) && $past(op_q) == op_rst_device)
    else $error("reset without enable frame");
  chk_one_status: assert property (@(posedge clk) disable iff (rst)
    done && op_q == op_wr_stat && wr_cnt_q == 2'h1 && sr_ok && !armed_q |=> $stable(sr2_q))
    else $error("status two written by one byte");
  chk_four_byte: assert property (@(posedge clk) disable iff (rst)
    one_byte && op_q == op_enter_4b && !pd_q && !armed_q |=> four_q) else $error("mode not set");
  chk_suspend_op: assert property (@(posedge clk) disable iff (rst)
    suspend_req |-> $past(op_q) == op_suspend && $past(idx_q) == 4'h1)
    else $error("suspend from wrong frame");
  chk_quiet_bus: assert property (@(posedge clk) disable iff (rst)
    !lk.cs_active |=> io_oe == 4'h0) else $error("driving while deselected");

endmodule

// File: quad_serial_flash_cmd_decoder_end.sv
`timescale 1ns/100ps

// File: quad_host_model.sv
`timescale 1ns/100ps
// Behavioural four-line host: makes the link clock, selects the device and shifts nibbles.
module quad_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] io_wire,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_host
);
  // The link clock stands low and the device is deselected between frames.
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    io_host = 4'h0;
  end

  // One link clock of 125 ns; the wire is taken at the rising edge.
  task automatic pulse(output logic [3:0] seen);
    #62.5 sclk = 1'b1;
    seen = io_wire;
    #62.5 sclk = 1'b0;
  endtask

  // Sends whole bytes high nibble first, then reads n_rx bytes back.
  task automatic frame(input logic [7:0] tx[$], input int n_rx, output logic [7:0] rx[$]);
    logic [3:0] hi;
    logic [3:0] lo;
    rx = {};
    @(posedge clk);
    #1 cs_n = 1'b0;
    foreach (tx[i]) begin
      io_host = tx[i][7:4];
      pulse(hi);
      io_host = tx[i][3:0];
      pulse(lo);
    end
    // Released lines show the inverse of the last nibble, so stale data never matches.
    io_host = ~io_host;
    repeat (n_rx) begin
      pulse(hi);
      pulse(lo);
      rx.push_back({hi, lo});
    end
    #62.5 cs_n = 1'b1;
    #400;
  endtask
endmodule

// File: test_quad_serial_flash_cmd_decoder.sv
`timescale 1ns/100ps
module test_quad_serial_flash_cmd_decoder;
  import qflash_pkg::*;
  localparam logic [7:0] ident = 8'h3C;  // Arbitrary value.
  logic         clk, rst, sclk, cs_n, exec_req, prog_valid, wel, fbm, pd, susp, resm, srst;
  logic [3:0]   io_host, io_out, io_oe, io_wire;
  logic [4:0]   pul;
  logic [7:0]   lock_data, read_data, exec_op, prog_data, sr1, sr2, sr3, s1, s2, s3, rpb, uab;
  logic [7:0]   rd_op[3], rd_exp[3];
  logic [31:0]  read_addr, cmd_addr, prog_addr, a, wn;
  logic [127:0] uid;
  wrap_sel_type wrap_sel;
  logic [7:0]   rx[$];
  logic [39:0]  prog_q[$];
  int           n_mismatch, n_checks, cnt[5], w;

  // The device drives the wire only while it enables its outputs.
  assign io_wire = (io_oe != 4'h0) ? io_out : io_host;
  assign read_data = mem(read_addr);
  assign pul = {srst, resm, susp, exec_req, |io_oe};

  quad_serial_flash_cmd_decoder #(.device_ident(ident), .page_bytes(256))
    u_quad_serial_flash_cmd_decoder (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_wire), .io_out(io_out),
    .io_oe(io_oe), .wrap_sel(wrap_sel), .read_data(read_data), .lock_data(lock_data),
    .unique_identifier(uid), .read_addr(read_addr), .cmd_addr(cmd_addr),
    .exec_req(exec_req), .exec_op(exec_op), .prog_valid(prog_valid), .prog_addr(prog_addr),
    .prog_data(prog_data), .status_byte_one(sr1), .status_byte_two(sr2),
    .status_byte_three(sr3), .read_parameter_byte(rpb), .upper_address_byte(uab),
    .write_enable_latch(wel), .four_byte_mode(fbm), .power_down(pd), .suspend_req(susp),
    .resume_req(resm), .soft_reset(srst));

  quad_host_model u_quad_host_model (
    .clk(clk), .io_wire(io_wire), .sclk(sclk), .cs_n(cs_n), .io_host(io_host));

  // Array contents seen by the decoder; mixing two address bytes catches stuck bits.
  function automatic logic [7:0] mem(input logic [31:0] x);
    return x[7:0] ^ x[23:16] ^ 8'h96;
  endfunction

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic f(input logic [7:0] tx[$], input int n = 0);
    u_quad_host_model.frame(tx, n, rx);
  endtask

  // Streamed read from s; win of zero means no wrap window.
  task automatic rd(input logic [31:0] s, input logic [7:0] tx[$], input int n,
                    input logic [31:0] win);
    logic [31:0] e;
    f(tx, n);
    check("stream length", rx.size(), n);
    foreach (rx[j]) begin
      e = (s & ~(win - 1)) | ((s + j) & (win - 1));
      check("stream byte", rx[j], mem(e));
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulse and output-enable counters, plus a log of program bytes.
  always @(posedge clk) begin
    foreach (cnt[k]) if (pul[k] === 1'b1) cnt[k]++;
    if (prog_valid === 1'b1) prog_q.push_back({prog_addr, prog_data});
  end

  // A hang ends at 1 ms, about fourteen times the length of the whole sequence.
  initial begin
    #1000000;
    n_mismatch++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    w = $urandom(59984);
    wrap_sel = 2'h0;
    lock_data = 8'($urandom);
    uid = {$urandom, $urandom, $urandom, $urandom};
    s1 = 8'($urandom);
    s2 = 8'h80;
    s3 = 8'($urandom);
    rd_op = '{op_rd_stat1, op_rd_stat2, op_rd_stat3};
    rd_exp = '{s3, s1, s2};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    check("reset state", {sr1, sr2, sr3, wel, fbm, pd, io_oe}, '0);
    f('{op_wr_stat, s1, s2});
    check("status one unlatched", sr1, 8'h00);
    f('{op_wr_enable});
    check("write latch", wel, 1'b1);
    f('{op_wr_disable});
    check("write latch cleared", wel, 1'b0);
    f('{op_wr_enable});
    f('{op_wr_stat, s1, s2});
    check("status pair", {sr1, sr2, wel}, {s1, s2, 1'b0});
    f('{op_wr_enable});
    f('{op_wr_stat, s3});
    check("status one only", {sr1, sr2}, {s3, s2});
    f('{op_vol_enable});
    f('{op_wr_stat2, s1});
    check("status two", sr2, s1);
    f('{op_wr_enable});
    f('{op_wr_stat3, s2});
    check("status three", sr3, s2);
    foreach (rd_op[k]) begin
      f('{rd_op[k]}, 3);
      foreach (rx[j]) check("status read", rx[j], rd_exp[k]);
    end
    cnt = '{default: 0};
    f('{op_suspend});
    f('{op_resume});
    check("suspend and resume", {cnt[2], cnt[3]}, {32'd1, 32'd1});
    f('{op_power_down});
    cnt = '{default: 0};
    f('{op_rd_stat1}, 1);
    check("no drive in power-down", {pd, cnt[0]}, {1'b1, 32'd0});
    f('{op_release_id, 8'h00, 8'h00, 8'h00}, 2);
    check("ident byte", {rx[0], rx[1], pd}, {ident, ident, 1'b0});
    f('{op_release_id, 8'h00, 8'h00, 8'h00}, 1);
    check("ident awake", rx[0], ident);
    f('{op_unique_id, 8'h00, 8'h00, 8'h00, 8'h00}, 17);
    foreach (rx[j]) check("identifier byte", rx[j], uid[127 - 8 * (j % 16) -: 8]);
    a = {8'h00, 24'($urandom)};
    rd(a, '{op_fast_read, a[23:16], a[15:8], a[7:0], 8'h00}, 4, 0);
    for (int ws = 0; ws < 4; ws++) begin
      @(posedge clk);
      #1 wrap_sel = 2'(ws);
      wn = 32'd8 << ws;
      a = ({8'h00, 24'($urandom)} & ~(wn - 1)) | (wn - 2);
      rd(a, '{op_wrap_read, a[23:16], a[15:8], a[7:0], 8'h00}, 4, wn);
    end
    f('{op_lock_read, a[23:16], a[15:8], a[7:0]}, 1);
    check("lock byte", rx[0], lock_data);
    f('{op_enter_4b});
    check("four-byte mode", fbm, 1'b1);
    a = $urandom;
    rd(a, '{op_qio_read4, a[31:24], a[23:16], a[15:8], a[7:0], 8'hFF, 8'h00}, 3, 0);
    rd(a, '{op_fast_read, a[31:24], a[23:16], a[15:8], a[7:0], 8'h00}, 2, 0);
    a[31:24] = 8'h00;
    rd(a, '{op_param_table, a[23:16], a[15:8], a[7:0], 8'h00}, 2, 0);
    f('{op_set_param, s1});
    check("parameter byte", rpb, s1);
    f('{op_wr_upper, 8'h5D});
    f('{op_rd_upper}, 2);
    check("upper byte", {rx[0], rx[1], uab}, {8'h5D, 8'h5D, 8'h5D});
    cnt = '{default: 0};
    f('{op_rst_enable});
    f('{op_rd_stat1});
    f('{op_rst_device});
    check("reset disarmed", {cnt[4], fbm}, {32'd0, 1'b1});
    f('{op_rst_enable});
    f('{op_rst_device});
    check("soft reset", {cnt[4], fbm, sr1, uab}, {32'd1, 1'b0, s3, 8'h00});
    a[7:0] = 8'hFE;
    prog_q = {};
    f('{op_prog, a[23:16], a[15:8], a[7:0], rd_exp[0], rd_exp[1], rd_exp[2]});
    check("program unlatched", prog_q.size(), 0);
    f('{op_wr_enable});
    f('{op_prog, a[23:16], a[15:8], a[7:0], rd_exp[0], rd_exp[1], rd_exp[2]});
    check("program count", {prog_q.size(), wel}, {32'd3, 1'b0});
    foreach (prog_q[j]) check("program byte", prog_q[j], {a[31:8], 8'(8'hFE + j), rd_exp[j]});
    cnt = '{default: 0};
    f('{op_era4k, a[23:16], a[15:8], a[7:0]});
    check("erase unlatched", cnt[1], 0);
    f('{op_wr_enable});
    f('{op_era4k, a[23:16], a[15:8], a[7:0]});
    check("erase", {cnt[1], exec_op, cmd_addr, wel}, {32'd1, op_era4k, a, 1'b0});
    f('{op_wr_enable});
    f('{op_chip_era_b});
    check("chip erase", {cnt[1], exec_op, wel}, {32'd2, op_chip_era_b, 1'b0});
    rd(a, '{op_qio_read, a[23:16], a[15:8], a[7:0], 8'hFF, 8'h00}, 2, 0);
    final_report;
  end
endmodule
